// File: rtl/srs_pkg.sv
`default_nettype none
package srs_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] OFF_PRIMARY  = 8'h00;
  localparam logic [7:0] OFF_RCS      = 8'h04;
  localparam logic [7:0] OFF_VEC      = 8'h08;
  localparam logic [7:0] OFF_CMD      = 8'h0C;
  localparam logic [7:0] OFF_ICTL     = 8'h10;
  localparam logic [7:0] OFF_VBASE    = 8'h14;
  localparam logic [7:0] OFF_FMT      = 8'h18;
  localparam logic [7:0] OFF_RXDATA   = 8'h1C;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h20;
  localparam logic [7:0] OFF_IRQ_CLR  = 8'h24;
  localparam logic [7:0] OFF_IRQ_EN   = 8'h28;
  localparam logic [7:0] REG_RESET    = 8'h00;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
  // ****************************************
  // fields
  // ****************************************
  localparam int CMD_LSB      = 3;
  localparam logic [2:0] CMD_EXT_RESET = 3'h2;
  localparam logic [2:0] CMD_ERR_RESET = 3'h6;
  localparam int ICTL_SAV     = 2;
  localparam int FMT_PAR      = 0;
  localparam int FMT_MODE_LSB = 4;
  localparam int FMT_LEN_LSB  = 6;
  localparam int RCS_ALL_SENT = 0;
  localparam int RCS_RES_LSB  = 1;
  localparam int RCS_PAR      = 4;
  localparam int RCS_OVR      = 5;
  localparam int RCS_CRC      = 6;
  localparam int RCS_EOF      = 7;
  localparam int PRI_RX_AVAIL = 0;
  localparam int PRI_BREAK    = 7;
  localparam int IRQ_W        = 3;
  localparam int IRQ_EXT      = 0;
  localparam int IRQ_RX       = 1;
  localparam int IRQ_SPC      = 2;
  localparam int VEC_LSB      = 1;
  localparam logic [2:0] VEC_NONE = 3'h0;
  localparam logic [2:0] VEC_EXT  = 3'h1;
  localparam logic [2:0] VEC_RX   = 3'h2;
  localparam logic [2:0] VEC_SPC  = 3'h3;
  localparam logic [2:0] RES_RESET = 3'h1;
  localparam int FIFO_DEPTH   = 3;
  localparam logic [1:0] FIFO_FULL = 2'h3;

  typedef enum logic [1:0] {SRS_ASYNC, SRS_SYNC, SRS_SDLC, SRS_SPARE} srs_mode_e;

  // residue code in register order {d3,d2,d1}; tail wraps mod 8
  function automatic logic [2:0] srs_residue(input logic [1:0] len, input logic [3:0] tail);
    logic [2:0] base;
    logic [2:0] v;
    case (len)
      2'h0:    base = 3'h4;
      2'h1:    base = 3'h2;
      2'h2:    base = 3'h0;
      default: base = 3'h6;
    endcase
    v = base + tail[2:0] - {1'b0, len} - 3'h5;
    return {v[0], v[1], v[2]};
  endfunction : srs_residue

  function automatic logic [2:0] srs_vec_pick(input logic [IRQ_W-1:0] p);
    if (p[IRQ_SPC])
      return VEC_SPC;
    else if (p[IRQ_RX])
      return VEC_RX;
    else if (p[IRQ_EXT])
      return VEC_EXT;
    else
      return VEC_NONE;
  endfunction : srs_vec_pick
endpackage : srs_pkg
`default_nettype wire

// File: rtl/srs_rx_fifo.sv
`default_nettype none
module srs_rx_fifo
  import srs_pkg::*;
(
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // fill side
  input  wire logic       push,
  input  wire logic [7:0] push_data,
  // drain side
  input  wire logic       pop,
  output logic            avail,
  output logic [7:0]      head_data,
  output logic            ovr_evt
);
  typedef struct packed {
    logic [FIFO_DEPTH-1:0][7:0] data;
    logic [FIFO_DEPTH-1:0]      tag;
    logic [1:0]                 count;
  } srs_fifo_s;

  srs_fifo_s st_ff;
  srs_fifo_s nxt_st;
  logic      do_pop;

  assign do_pop    = pop && (st_ff.count != 2'h0);
  assign avail     = st_ff.count != 2'h0;
  assign head_data = st_ff.data[0];
  assign ovr_evt   = do_pop && st_ff.tag[0];

  always_comb begin
    nxt_st = st_ff;
    if (do_pop) begin
      for (int i = 0; i < FIFO_DEPTH - 1; i++) begin
        nxt_st.data[i] = st_ff.data[i+1];
        nxt_st.tag[i]  = st_ff.tag[i+1];
      end
      nxt_st.tag[FIFO_DEPTH-1] = 1'b0;
      nxt_st.count = st_ff.count - 2'h1;
    end
    if (push) begin
      if (nxt_st.count == FIFO_FULL) begin
        nxt_st.data[FIFO_DEPTH-1] = push_data;
        nxt_st.tag[FIFO_DEPTH-1]  = 1'b1;
      end else begin
        nxt_st.data[nxt_st.count] = push_data;
        nxt_st.tag[nxt_st.count]  = 1'b0;
        nxt_st.count = nxt_st.count + 2'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  chk_fifo_overwrite: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (push && !pop && st_ff.count == FIFO_FULL) |=>
      (st_ff.tag[FIFO_DEPTH-1] && st_ff.count == FIFO_FULL)
  ) else $error("overwrite of full fifo not tagged");
endmodule : srs_rx_fifo
`default_nettype wire

// File: rtl/srs_irq_core.sv
`default_nettype none
module srs_irq_core
  import srs_pkg::*;
(
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // events and software access
  input  wire logic [IRQ_W-1:0] evt,
  input  wire logic             clr_we,
  input  wire logic             en_we,
  input  wire logic [IRQ_W-1:0] wr_data,
  // state
  output logic [IRQ_W-1:0]      status,
  output logic [IRQ_W-1:0]      enable,
  output logic                  irq
);
  typedef struct packed {
    logic [IRQ_W-1:0] status;
    logic [IRQ_W-1:0] enable;
  } srs_irq_s;

  srs_irq_s st_ff;
  srs_irq_s nxt_st;

  assign status = st_ff.status;
  assign enable = st_ff.enable;
  assign irq    = |(st_ff.status & st_ff.enable);

  always_comb begin
    nxt_st = st_ff;
    // set beats clear so no event is lost
    nxt_st.status = (st_ff.status & ~(clr_we ? wr_data : '0)) | evt;
    if (en_we)
      nxt_st.enable = wr_data;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  chk_irq_sticky: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (st_ff.status[0] && !(clr_we && wr_data[0])) |=> st_ff.status[0]
  ) else $error("sticky status bit lost");
endmodule : srs_irq_core
`default_nettype wire

// File: rtl/srs_status_vector.sv
// The implementer's own choices: the AXI4-Lite register port and the address map.
`default_nettype none
module srs_status_vector
  import srs_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write channels
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read channels
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // receiver and transmitter status
  input  wire logic        rx_break,
  input  wire logic        rx_abort,
  input  wire logic        rx_char_strobe,
  input  wire logic [7:0]  rx_char_data,
  input  wire logic        rx_parity_bad,
  input  wire logic        rx_frame_bad,
  input  wire logic        rx_crc_bad,
  input  wire logic        rx_eof,
  input  wire logic [3:0]  rx_tail_bits,
  input  wire logic        tx_idle,
  // interrupt
  output logic             irq
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic       aw_held;
    logic [7:0] aw_addr;
    logic       w_held;
    logic [7:0] w_data;
    logic       w_lane0;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [7:0] fmt;
    logic [7:0] ictl;
    logic [7:0] vbase;
    logic       brk_abort;
    logic       brk_prev;
    logic       par_err;
    logic       ovr_err;
    logic       crc_err;
    logic       frm_err;
    logic       eof;
    logic       eof_wait;
    logic [2:0] residue;
  } srs_top_s;

  srs_top_s         st_ff;
  srs_top_s         nxt_st;
  srs_mode_e        mode;
  logic             is_async;
  logic             is_sdlc;
  logic [1:0]       len;
  logic             wr_fire;
  logic             rd_fire;
  logic             wr_ok;
  logic             cmd_ext;
  logic             cmd_err;
  logic             brk_rise;
  logic             brk_fall;
  logic             abort_evt;
  logic             par_evt;
  logic             crc_evt;
  logic             eof_evt;
  logic             frm_evt;
  logic             fifo_pop;
  logic             fifo_avail;
  logic [7:0]       fifo_head;
  logic             ovr_evt;
  logic [IRQ_W-1:0] irq_evt;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_en;
  logic [7:0]       pri_word;
  logic [7:0]       rcs_word;
  logic [7:0]       vec_word;

  // ****************************************
  // decode
  // ****************************************
  assign mode     = srs_mode_e'(st_ff.fmt[FMT_MODE_LSB +: 2]);
  assign is_async = mode == SRS_ASYNC;
  assign is_sdlc  = mode == SRS_SDLC;
  assign len      = st_ff.fmt[FMT_LEN_LSB +: 2];

  assign s_axi_awready = !st_ff.aw_held;
  assign s_axi_wready  = !st_ff.w_held;
  assign s_axi_arready = !st_ff.rvalid;
  assign s_axi_bvalid  = st_ff.bvalid;
  assign s_axi_bresp   = st_ff.bresp;
  assign s_axi_rvalid  = st_ff.rvalid;
  assign s_axi_rresp   = st_ff.rresp;
  assign s_axi_rdata   = {24'h000000, st_ff.rdata};

  // one write in flight: the response must drain before the next
  assign wr_fire = st_ff.aw_held && st_ff.w_held && !st_ff.bvalid;
  assign rd_fire = s_axi_arvalid && !st_ff.rvalid;
  assign wr_ok   = st_ff.aw_addr inside {OFF_CMD, OFF_ICTL, OFF_VBASE, OFF_FMT,
                                         OFF_IRQ_CLR, OFF_IRQ_EN};
  assign cmd_ext = wr_fire && st_ff.w_lane0 && st_ff.aw_addr == OFF_CMD &&
                   st_ff.w_data[CMD_LSB +: 3] == CMD_EXT_RESET;
  assign cmd_err = wr_fire && st_ff.w_lane0 && st_ff.aw_addr == OFF_CMD &&
                   st_ff.w_data[CMD_LSB +: 3] == CMD_ERR_RESET;

  // ****************************************
  // receive events
  // ****************************************
  // break onset and end
  assign brk_rise  = is_async && rx_break && !st_ff.brk_prev;
  assign brk_fall  = is_async && !rx_break && st_ff.brk_prev;
  assign abort_evt = is_sdlc && rx_abort;
  assign par_evt   = rx_char_strobe && st_ff.fmt[FMT_PAR] && rx_parity_bad;
  assign crc_evt   = !is_async && rx_crc_bad;
  assign eof_evt   = is_sdlc && rx_eof;
  assign frm_evt   = is_async && rx_char_strobe && rx_frame_bad;
  assign fifo_pop  = rd_fire && s_axi_araddr == OFF_RXDATA;

  assign irq_evt[IRQ_EXT] = brk_rise || brk_fall || abort_evt;
  assign irq_evt[IRQ_RX]  = rx_char_strobe;
  assign irq_evt[IRQ_SPC] = par_evt || ovr_evt || crc_evt || eof_evt || frm_evt;

  // ****************************************
  // read words
  // ****************************************
  assign pri_word = {st_ff.brk_abort, 6'h00, fifo_avail};
  always_comb begin
    rcs_word = 8'h00;
    rcs_word[RCS_ALL_SENT] = is_async ? tx_idle : 1'b1;
    // residue held from end of frame
    rcs_word[RCS_RES_LSB +: 3] = st_ff.residue;
    rcs_word[RCS_PAR] = st_ff.par_err;
    rcs_word[RCS_OVR] = st_ff.ovr_err;
    rcs_word[RCS_CRC] = is_async ? st_ff.frm_err : st_ff.crc_err;
    rcs_word[RCS_EOF] = st_ff.eof;
  end
  always_comb begin
    vec_word = st_ff.vbase;
    if (st_ff.ictl[ICTL_SAV])
      vec_word[VEC_LSB +: 3] = srs_vec_pick(irq_stat & irq_en);
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    nxt_st = st_ff;
    if (s_axi_awvalid && !st_ff.aw_held) begin
      nxt_st.aw_held = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_ff.w_held) begin
      nxt_st.w_held  = 1'b1;
      nxt_st.w_data  = s_axi_wdata[7:0];
      nxt_st.w_lane0 = s_axi_wstrb[0];
    end
    if (st_ff.bvalid && s_axi_bready)
      nxt_st.bvalid = 1'b0;
    if (wr_fire) begin
      nxt_st.aw_held = 1'b0;
      nxt_st.w_held  = 1'b0;
      nxt_st.bvalid  = 1'b1;
      nxt_st.bresp   = wr_ok ? RESP_OKAY : RESP_SLVERR;
      if (st_ff.w_lane0) begin
        case (st_ff.aw_addr)
          OFF_ICTL:  nxt_st.ictl  = st_ff.w_data;
          OFF_VBASE: nxt_st.vbase = st_ff.w_data;
          OFF_FMT:   nxt_st.fmt   = st_ff.w_data;
          default:   ;
        endcase
      end
    end
    if (st_ff.rvalid && s_axi_rready)
      nxt_st.rvalid = 1'b0;
    if (rd_fire) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp  = RESP_OKAY;
      case (s_axi_araddr)
        OFF_PRIMARY:  nxt_st.rdata = pri_word;
        OFF_RCS:      nxt_st.rdata = rcs_word;
        OFF_VEC:      nxt_st.rdata = vec_word;
        OFF_ICTL:     nxt_st.rdata = st_ff.ictl;
        OFF_VBASE:    nxt_st.rdata = st_ff.vbase;
        OFF_FMT:      nxt_st.rdata = st_ff.fmt;
        OFF_RXDATA:   nxt_st.rdata = fifo_head;
        OFF_IRQ_STAT: nxt_st.rdata = {5'h00, irq_stat};
        OFF_IRQ_EN:   nxt_st.rdata = {5'h00, irq_en};
        default: begin
          nxt_st.rdata = 8'h00;
          nxt_st.rresp = RESP_SLVERR;
        end
      endcase
    end
    nxt_st.brk_prev = rx_break;
    // cleared by command only, set wins
    nxt_st.brk_abort = (st_ff.brk_abort && !cmd_ext) || brk_rise || abort_evt;
    nxt_st.par_err = (st_ff.par_err && !cmd_err) || par_evt;
    nxt_st.ovr_err = (st_ff.ovr_err && !cmd_err) || ovr_evt;
    nxt_st.crc_err = (st_ff.crc_err && !cmd_err) || crc_evt;
    // closing flag sets end of frame
    nxt_st.eof = (st_ff.eof && !cmd_err) || eof_evt;
    if (is_async && rx_char_strobe)
      nxt_st.frm_err = rx_frame_bad;
    // next frame first char refreshes residue
    if (rx_char_strobe && st_ff.eof_wait) begin
      nxt_st.eof_wait = 1'b0;
      nxt_st.residue  = srs_residue(len, {2'h0, len} + 4'h5);
    end
    if (eof_evt) begin
      nxt_st.eof_wait = 1'b1;
      nxt_st.residue  = srs_residue(len, rx_tail_bits);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff         <= '0;
      st_ff.fmt     <= REG_RESET;
      st_ff.ictl    <= REG_RESET;
      st_ff.vbase   <= REG_RESET;
      st_ff.residue <= RES_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  srs_rx_fifo u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .push      (rx_char_strobe),
    .push_data (rx_char_data),
    .pop       (fifo_pop),
    .avail     (fifo_avail),
    .head_data (fifo_head),
    .ovr_evt   (ovr_evt)
  );

  srs_irq_core u_irq (
    .aclk    (aclk),
    .aresetn (aresetn),
    .evt     (irq_evt),
    .clr_we  (wr_fire && st_ff.w_lane0 && st_ff.aw_addr == OFF_IRQ_CLR),
    .en_we   (wr_fire && st_ff.w_lane0 && st_ff.aw_addr == OFF_IRQ_EN),
    .wr_data (st_ff.w_data[IRQ_W-1:0]),
    .status  (irq_stat),
    .enable  (irq_en),
    .irq     (irq)
  );

  // ****************************************
  // checks
  // ****************************************
  chk_break_set: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (is_async && rx_break && !st_ff.brk_prev) |=> (st_ff.brk_abort && irq_stat[IRQ_EXT])
  ) else $error("break did not set flag and interrupt");
  chk_break_hold: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (st_ff.brk_abort && !cmd_ext) |=> st_ff.brk_abort
  ) else $error("break flag dropped without command");
  chk_break_end: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (is_async && !rx_break && st_ff.brk_prev) |=> irq_stat[IRQ_EXT]
  ) else $error("break end gave no interrupt");
  chk_abort_set: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (is_sdlc && rx_abort) |=> (st_ff.brk_abort && irq_stat[IRQ_EXT])
  ) else $error("abort did not set flag");
  chk_allsent_sync: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !is_async |-> rcs_word[RCS_ALL_SENT]
  ) else $error("all sent clear in sync mode");
  chk_parity_latch: assert property (
    @(posedge aclk) disable iff (!aresetn)
    par_evt |=> st_ff.par_err ##1 (st_ff.par_err || $past(cmd_err))
  ) else $error("parity error not latched");
  chk_err_reset: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (cmd_err && !par_evt && !crc_evt) |=> (!st_ff.par_err && !st_ff.crc_err)
  ) else $error("error reset did not clear");
  chk_frame_follow: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (is_async && rx_char_strobe) |=> (rcs_word[RCS_CRC] == $past(rx_frame_bad) || !is_async)
  ) else $error("framing bit not updated");
  chk_residue_eof: assert property (
    @(posedge aclk) disable iff (!aresetn)
    eof_evt |=> (st_ff.eof && st_ff.residue == $past(srs_residue(len, rx_tail_bits)))
  ) else $error("residue not captured at end of frame");
  chk_vec_plain: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !st_ff.ictl[ICTL_SAV] |-> vec_word == st_ff.vbase
  ) else $error("vector differs from base");
  chk_vec_status: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (st_ff.ictl[ICTL_SAV] && irq_stat[IRQ_SPC] && irq_en[IRQ_SPC]) |-> vec_word[3:1] == VEC_SPC
  ) else $error("vector ignores top condition");
endmodule : srs_status_vector
`default_nettype wire

// File: verification/srs_line_model.sv
`default_nettype none
module srs_line_model (
  // clock
  input  wire logic  aclk,
  // line status toward the block
  output logic       rx_break,
  output logic       rx_abort,
  output logic       rx_char_strobe,
  output logic [7:0] rx_char_data,
  output logic       rx_parity_bad,
  output logic       rx_frame_bad,
  output logic       rx_crc_bad,
  output logic       rx_eof,
  output logic [3:0] rx_tail_bits,
  output logic       tx_idle
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {rx_break, rx_abort, rx_char_strobe, rx_crc_bad, rx_eof, tx_idle} = 6'h00;
    {rx_char_data, rx_parity_bad, rx_frame_bad, rx_tail_bits} = 14'h3FFF;
  end
  // ****
  // stimulus
  // ****
  // qualifiers go stale outside the strobe, so a late sample is caught
  task automatic send_char(input logic [7:0] d, input logic pb, input logic fb);
    @(posedge aclk);
    rx_char_strobe <= 1'b1;
    {rx_char_data, rx_parity_bad, rx_frame_bad} <= {d, pb, fb};
    @(posedge aclk);
    rx_char_strobe <= 1'b0;
    {rx_char_data, rx_parity_bad, rx_frame_bad} <= ~{d, pb, fb};
  endtask : send_char
  // kind 0 abort, 1 crc error, 2 closing flag
  task automatic pulse(input logic [1:0] kind, input logic [3:0] tail);
    @(posedge aclk);
    {rx_abort, rx_crc_bad, rx_eof} <= {kind == 2'h0, kind == 2'h1, kind == 2'h2};
    rx_tail_bits <= tail;
    @(posedge aclk);
    {rx_abort, rx_crc_bad, rx_eof} <= 3'h0;
    rx_tail_bits <= ~tail;
  endtask : pulse
  task automatic levels(input logic brk, input logic idle);
    @(posedge aclk);
    {rx_break, tx_idle} <= {brk, idle};
  endtask : levels
endmodule : srs_line_model
`default_nettype wire

// File: verification/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import srs_pkg::*;
  typedef struct packed {
    logic        is_wr;
    logic [7:0]  addr;
    logic [7:0]  data;
    logic [31:0] exp;
    logic [1:0]  resp;
  } srs_row_s;
  // ****
  // signals
  // ****
  logic        aclk, aresetn, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0]  s_axi_wstrb, rx_tail_bits;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        rx_break, rx_abort, rx_char_strobe, rx_parity_bad, rx_frame_bad;
  logic        rx_crc_bad, rx_eof, tx_idle;
  logic [7:0]  rx_char_data;
  logic [2:0]  v;
  logic [2:0]  nores [4] = '{3'h1, 3'h2, 3'h0, 3'h3};
  int          err_total, checks_done;
  srs_row_s    rows [10] = '{
    '{1'b0, OFF_RCS, 8'h00, 32'h0000_0002, RESP_OKAY},
    '{1'b1, OFF_VBASE, 8'hA5, 32'h0, RESP_OKAY},
    '{1'b0, OFF_VEC, 8'h00, 32'h0000_00A5, RESP_OKAY},
    '{1'b1, OFF_FMT, 8'hC1, 32'h0, RESP_OKAY},
    '{1'b0, OFF_FMT, 8'h00, 32'h0000_00C1, RESP_OKAY},
    '{1'b1, OFF_RCS, 8'hFF, 32'h0, RESP_SLVERR},
    '{1'b0, OFF_RCS, 8'h00, 32'h0000_0002, RESP_OKAY},
    '{1'b0, 8'h2C, 8'h00, 32'h0, RESP_SLVERR},
    '{1'b0, OFF_PRIMARY, 8'h00, 32'h0, RESP_OKAY},
    '{1'b1, OFF_IRQ_EN, 8'h07, 32'h0, RESP_OKAY}};

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  srs_status_vector u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_break, .rx_abort, .rx_char_strobe,
    .rx_char_data, .rx_parity_bad, .rx_frame_bad, .rx_crc_bad, .rx_eof, .rx_tail_bits,
    .tx_idle, .irq);
  srs_line_model u_line (.aclk, .rx_break, .rx_abort, .rx_char_strobe, .rx_char_data,
    .rx_parity_bad, .rx_frame_bad, .rx_crc_bad, .rx_eof, .rx_tail_bits, .tx_idle);

  // ****
  // tasks
  // ****
  task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_reg
  task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
    check_reg({30'h0, got}, {30'h0, exp});
  endtask : check_resp
  task automatic check_pin(input logic got, input logic exp);
    check_reg({31'h0, got}, {31'h0, exp});
  endtask : check_pin
  task automatic complete_run;
    $display("mismatches %0d, comparisons %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run
  // address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, 24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        {d, r} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : axi_rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    axi_wr(a, d, rsp);
    check_resp(rsp, RESP_OKAY);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    axi_rd(a, rdat, rsp);
    check_reg(rdat & m, e);
  endtask : rd

  // ****
  // sequence
  // ****
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'h1;
    err_total = 0;
    checks_done = 0;
    aresetn = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].is_wr) begin
        axi_wr(rows[i].addr, rows[i].data, rsp);
      end else begin
        axi_rd(rows[i].addr, rdat, rsp);
        check_reg(rdat, rows[i].exp);
      end
      check_resp(rsp, rows[i].resp);
    end
    u_line.levels(1'b1, 1'b0);
    rd(OFF_PRIMARY, 32'hFF, 32'h80);
    check_pin(irq, 1'b1);
    wr(OFF_IRQ_EN, 8'h00);
    check_pin(irq, 1'b0);
    wr(OFF_IRQ_EN, 8'h07);
    wr(OFF_IRQ_CLR, 8'h01);
    rd(OFF_IRQ_STAT, 32'hFF, 32'h00);
    rd(OFF_PRIMARY, 32'hFF, 32'h80);
    u_line.levels(1'b0, 1'b0);
    rd(OFF_IRQ_STAT, 32'hFF, 32'h01);
    wr(OFF_CMD, 8'h10);
    rd(OFF_PRIMARY, 32'hFF, 32'h00);
    u_line.send_char(8'h11, 1'b1, 1'b1);
    rd(OFF_RCS, 32'hF1, 32'h50);
    u_line.send_char(8'h22, 1'b0, 1'b0);
    rd(OFF_RCS, 32'hF1, 32'h10);
    u_line.send_char(8'h33, 1'b0, 1'b0);
    u_line.send_char(8'h44, 1'b0, 1'b0);
    rd(OFF_RXDATA, 32'hFF, 32'h11);
    rd(OFF_RXDATA, 32'hFF, 32'h22);
    rd(OFF_RXDATA, 32'hFF, 32'h44);
    rd(OFF_RCS, 32'hF1, 32'h30);
    wr(OFF_ICTL, 8'h04);
    rd(OFF_VEC, 32'hFF, 32'hA7);
    wr(OFF_IRQ_CLR, 8'h04);
    rd(OFF_VEC, 32'hFF, 32'hA5);
    wr(OFF_IRQ_CLR, 8'h07);
    rd(OFF_VEC, 32'hFF, 32'hA1);
    wr(OFF_CMD, 8'h30);
    rd(OFF_RCS, 32'hF1, 32'h00);
    u_line.levels(1'b0, 1'b1);
    rd(OFF_RCS, 32'h01, 32'h01);
    wr(OFF_FMT, 8'hE0);
    u_line.pulse(2'h0, 4'h0);
    rd(OFF_PRIMARY, 32'h80, 32'h80);
    rd(OFF_VEC, 32'hFF, 32'hA3);
    wr(OFF_CMD, 8'h10);
    for (int i = 0; i < 8; i++) begin
      v = 3'(i + 1);
      u_line.pulse(2'h2, 4'(i + 3));
      rd(OFF_RCS, 32'hFF, {24'h0, 4'h8, v[0], v[1], v[2], 1'b1});
    end
    u_line.pulse(2'h1, 4'h0);
    rd(OFF_RCS, 32'hC0, 32'hC0);
    wr(OFF_CMD, 8'h30);
    rd(OFF_RCS, 32'hC0, 32'h00);
    for (int l = 0; l < 4; l++) begin
      wr(OFF_FMT, {2'(l), 6'h20});
      u_line.pulse(2'h2, 4'(l + 5));
      u_line.send_char(8'h5A, 1'b1, 1'b0);
      rd(OFF_RCS, 32'h1E, {27'h0, 1'b0, nores[l], 1'b0});
    end
    // mid-run reset: flags, interrupt and fifo must fall back to idle
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    check_pin(irq, 1'b0);
    rd(OFF_RCS, 32'hFF, 32'h03);
    rd(OFF_PRIMARY, 32'hFF, 32'h00);
    complete_run();
  end

  // a stuck handshake would otherwise hang the run
  initial begin
    repeat (5000) @(posedge aclk);
    err_total++;
    complete_run();
  end
endmodule : testbench
`default_nettype wire
